// ==== hw/six_pin_gpio_port.sv ====
// six pin bidirectional port with pull-ups and change detection
`timescale 1ns/10ps
// Overview of operation
// - direction bit 1 turns the pin driver off, pin is input.
// - direction bit 0 drives the pin from its output latch.
// - pin 3 is input only; its direction bit always reads 1.
// - data read returns synchronised pin levels; data write loads the latch.
// - each data write is read-modify-write of pin levels into the whole latch.
// - pin 3 data reads 0 while master clear enable is set.
// - direction still controls analog pins; analog pins read 0.
// - port is six bits; bits 7 and 6 read 0.
// - pins other than 3 have a pull-up gated by its enable bit.
// - a pin driven as output has its pull-up forced off.
// - pull-ups act only when global control allows; disabled after reset.
// - per-pin change enables, all 0 after reset.
// - enabled pins compared with reference from last port read or write; OR sets flag.
// - set change flag raises the wake output.
// - mismatch keeps setting flag; port read or write reloads reference.
// - a change in the read cycle itself is still compared with the old reference.
// - change interrupt request only while global irq enable set.
// - an enabled peripheral takes over its pin.
module six_pin_gpio_port (
	input wire logic clk,
	input wire logic rst,
	input wire gpio_port_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic [5:0] padIn,
	output gpio_port_pkg::pad_drive_t pad,
	input wire gpio_port_pkg::periph_t periph,
	output logic portChangeIrq,
	output logic wakeRequest
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [5:0] syncA;
		logic [5:0] syncB;
		logic [5:0] latch;
		logic [5:0] direction;
		logic [5:0] pullupEnable;
		logic [5:0] changeIrqEnable;
		logic [5:0] analogSelect;
		logic [5:0] reference;
		logic portChangeFlag;
		logic pullupDisable;
		logic masterClearEnable;
		logic globalIrqEnable;
		logic [7:0] rdata;
		gpio_port_pkg::pad_drive_t pad;
		logic irq;
		logic wake;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic [5:0] pinLevel;
	logic [5:0] mismatchBits;
	logic mismatch;
	logic portAccess;
	logic [5:0] dirView;
	logic [5:0] dataView;
	logic [5:0] modMask;
	logic [5:0] driveOut;
	logic [5:0] driveOe;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// two-stage pin synchroniser; syncA read only by syncB
		st_nxt.syncA = padIn;
		st_nxt.syncB = st_r.syncA;
		pinLevel = st_r.syncB;

		dirView = st_r.direction;
		dirView[gpio_port_pkg::INPUT_ONLY_PIN] = 1'b1;

		dataView = pinLevel & ~st_r.analogSelect;
		if (st_r.masterClearEnable) begin
			dataView[gpio_port_pkg::INPUT_ONLY_PIN] = 1'b0;
		end

		portAccess = (req.rd || req.wr) && (req.addr == gpio_port_pkg::OFF_PORT_DATA);
		modMask = req.wrMask[5:0];

		// register writes
		if (req.wr) begin
			unique case (req.addr)
				gpio_port_pkg::OFF_PORT_DATA: begin
					// pins read, addressed bits replaced, whole latch written
					st_nxt.latch = (pinLevel & ~modMask) | (req.wdata[5:0] & modMask);
				end
				gpio_port_pkg::OFF_PORT_DIRECTION: begin
					st_nxt.direction = req.wdata[5:0];
				end
				gpio_port_pkg::OFF_PULLUP_ENABLE: begin
					st_nxt.pullupEnable = req.wdata[5:0] & gpio_port_pkg::PULLUP_PRESENT;
				end
				gpio_port_pkg::OFF_CHANGE_IRQ_ENABLE: begin
					st_nxt.changeIrqEnable = req.wdata[5:0];
				end
				gpio_port_pkg::OFF_PORT_CONFIG: begin
					st_nxt.pullupDisable = req.wdata[gpio_port_pkg::CFG_PULLUP_DISABLE_BIT];
					st_nxt.masterClearEnable = req.wdata[gpio_port_pkg::CFG_MASTER_CLEAR_BIT];
					st_nxt.globalIrqEnable = req.wdata[gpio_port_pkg::CFG_GLOBAL_IRQ_BIT];
				end
				gpio_port_pkg::OFF_PORT_STATUS: begin
					// write one to clear; set below wins
					if (req.wdata[gpio_port_pkg::STS_CHANGE_FLAG_BIT]) begin
						st_nxt.portChangeFlag = 1'b0;
					end
				end
				gpio_port_pkg::OFF_ANALOG_SELECT: begin
					st_nxt.analogSelect = req.wdata[5:0];
				end
				default: begin
				end
			endcase
		end

		// change detection against reference from last port access
		mismatchBits = (pinLevel ^ st_r.reference) & st_r.changeIrqEnable;
		mismatch = |mismatchBits;
		if (mismatch) begin
			st_nxt.portChangeFlag = 1'b1;
		end
		// reference reload; a change landing in this cycle is still compared with the old reference
		if (portAccess) begin
			st_nxt.reference = pinLevel;
		end

		// register reads, data one cycle later
		st_nxt.rdata = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				gpio_port_pkg::OFF_PORT_DATA: st_nxt.rdata = {2'b00, dataView};
				gpio_port_pkg::OFF_PORT_DIRECTION: st_nxt.rdata = {2'b00, dirView};
				gpio_port_pkg::OFF_PULLUP_ENABLE: st_nxt.rdata = {2'b00, st_r.pullupEnable};
				gpio_port_pkg::OFF_CHANGE_IRQ_ENABLE: st_nxt.rdata = {2'b00, st_r.changeIrqEnable};
				gpio_port_pkg::OFF_PORT_CONFIG: begin
					st_nxt.rdata = {5'h00, st_r.globalIrqEnable, st_r.masterClearEnable,
						st_r.pullupDisable};
				end
				gpio_port_pkg::OFF_PORT_STATUS: begin
					st_nxt.rdata = {6'h00, mismatch, st_r.portChangeFlag};
				end
				gpio_port_pkg::OFF_ANALOG_SELECT: st_nxt.rdata = {2'b00, st_r.analogSelect};
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// pad drive; peripheral owns its pin when enabled
		driveOut = st_r.latch;
		driveOe = ~dirView & gpio_port_pkg::OUTPUT_CAPABLE;
		driveOut = (driveOut & ~periph.enable) | (periph.out & periph.enable);
		driveOe = (driveOe & ~periph.enable) | (periph.oe & periph.enable
			& gpio_port_pkg::OUTPUT_CAPABLE);
		st_nxt.pad.out = driveOut;
		st_nxt.pad.oe = driveOe;
		st_nxt.pad.pullupOn = st_r.pullupEnable & gpio_port_pkg::PULLUP_PRESENT
			& ~driveOe & {6{~st_r.pullupDisable}};

		st_nxt.wake = st_r.portChangeFlag;
		st_nxt.irq = st_r.portChangeFlag & st_r.globalIrqEnable;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.syncA <= 6'h00;
			st_r.syncB <= 6'h00;
			st_r.latch <= gpio_port_pkg::RST_LATCH;
			st_r.direction <= gpio_port_pkg::RST_DIRECTION;
			st_r.pullupEnable <= gpio_port_pkg::RST_PULLUP;
			st_r.changeIrqEnable <= gpio_port_pkg::RST_CHANGE_IRQ;
			st_r.analogSelect <= gpio_port_pkg::RST_ANALOG;
			st_r.reference <= 6'h00;
			st_r.portChangeFlag <= 1'b0;
			st_r.pullupDisable <= gpio_port_pkg::RST_PULLUP_DISABLE;
			st_r.masterClearEnable <= gpio_port_pkg::RST_MASTER_CLEAR;
			st_r.globalIrqEnable <= gpio_port_pkg::RST_GLOBAL_IRQ;
			st_r.rdata <= 8'h00;
			st_r.pad <= '0;
			st_r.irq <= 1'b0;
			st_r.wake <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata = st_r.rdata;
	assign pad = st_r.pad;
	assign portChangeIrq = st_r.irq;
	assign wakeRequest = st_r.wake;

endmodule : six_pin_gpio_port

// ==== hw/gpio_port_pkg.sv ====
// package: register map, reset values and carrier types of the six pin port
package gpio_port_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int PORT_W = 6;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int INPUT_ONLY_PIN = 3;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_PORT_DATA = 8'h05;
	localparam logic [7:0] OFF_PORT_DIRECTION = 8'h85;
	localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h95;
	localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h96;
	localparam logic [7:0] OFF_PORT_CONFIG = 8'ha0;
	localparam logic [7:0] OFF_PORT_STATUS = 8'ha1;
	localparam logic [7:0] OFF_ANALOG_SELECT = 8'ha2;

	// ------------------------------------------------------------
	// field positions in port_config and port_status
	// ------------------------------------------------------------
	localparam int CFG_PULLUP_DISABLE_BIT = 0;
	localparam int CFG_MASTER_CLEAR_BIT = 1;
	localparam int CFG_GLOBAL_IRQ_BIT = 2;
	localparam int STS_CHANGE_FLAG_BIT = 0;
	localparam int STS_MISMATCH_BIT = 1;

	// ------------------------------------------------------------
	// reset values and pin capability masks
	// ------------------------------------------------------------
	localparam logic [5:0] RST_DIRECTION = 6'h3f;
	localparam logic [5:0] RST_PULLUP = 6'h37;
	localparam logic [5:0] RST_CHANGE_IRQ = 6'h00;
	localparam logic [5:0] RST_ANALOG = 6'h00;
	localparam logic [5:0] RST_LATCH = 6'h00;
	localparam logic RST_PULLUP_DISABLE = 1'b1;
	localparam logic RST_MASTER_CLEAR = 1'b0;
	localparam logic RST_GLOBAL_IRQ = 1'b0;
	localparam logic [5:0] PULLUP_PRESENT = 6'h37;
	localparam logic [5:0] OUTPUT_CAPABLE = 6'h37;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] wrMask;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [PORT_W-1:0] enable;
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} periph_t;

	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
		logic [PORT_W-1:0] pullupOn;
	} pad_drive_t;

endpackage : gpio_port_pkg

// ==== sim/six_pin_gpio_port_asserts.sv ====
// checker: port relations of the six pin port
`timescale 1ns/10ps
module six_pin_gpio_port_asserts (
	input logic clk,
	input logic rst,
	input gpio_port_pkg::reg_req_t req,
	input logic [7:0] rdata,
	input gpio_port_pkg::pad_drive_t pad,
	input gpio_port_pkg::periph_t periph,
	input logic portChangeIrq,
	input logic wakeRequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_pin3; pad.oe[3] == 1'b0 && pad.pullupOn[3] == 1'b0; endproperty
	a_pin3: assert property (p_pin3) else $error("pin 3 driven");
	property p_pull; (pad.oe & pad.pullupOn) == 6'h00; endproperty
	a_pull: assert property (p_pull) else $error("pull-up on output");
	property p_rst; $past(rst) |-> {pad.oe, pad.pullupOn, wakeRequest} == 13'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_idle; !$past(req.rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	property p_high; $past(req.rd) |-> rdata[7:6] == 2'b00; endproperty
	a_high: assert property (p_high) else $error("upper bits set");
	property p_dir3; $past(req.rd) && $past(req.addr) == 8'h85 |-> rdata[3]; endproperty
	a_dir3: assert property (p_dir3) else $error("direction bit 3 clear");
	property p_irq; portChangeIrq |-> wakeRequest; endproperty
	a_irq: assert property (p_irq) else $error("irq without flag");
	property p_hold; wakeRequest && !$past(req.wr && req.addr == 8'ha1) |=> wakeRequest;
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped");
	property p_per; !$past(rst) |->
		((pad.oe ^ $past(periph.oe)) & $past(periph.enable) & 6'h37) == 6'h00; endproperty
	a_per: assert property (p_per) else $error("peripheral drive lost");
endmodule : six_pin_gpio_port_asserts

// ==== sim/pin_board.sv ====
// board model: outside drivers and weak pull-ups seen by the pins
`timescale 1ns/10ps
module pin_board (
	input gpio_port_pkg::pad_drive_t pad,
	input logic [5:0] drv,
	input logic [5:0] ext,
	output logic [5:0] padIn
);
	// released lines show noise from ext unless pulled up
	assign padIn = (pad.oe & pad.out) | (~pad.oe & (ext | (~drv & pad.pullupOn)));
endmodule : pin_board

// ==== sim/tb.sv ====
// testbench: bus driver, read result queue, pin scenarios
`timescale 1ns/10ps
module tb;
	logic clk, rst, rdPend, portChangeIrq, wakeRequest;
	logic [7:0] rdata, d, expQ[$];
	logic [5:0] padIn, drv, ext, e;
	gpio_port_pkg::reg_req_t req;
	gpio_port_pkg::pad_drive_t pad;
	gpio_port_pkg::periph_t periph;
	gpio_port_pkg::periph_t p;
	int errors = 0, checks_done = 0, n;
	six_pin_gpio_port u_dut (.clk, .rst, .req, .rdata, .padIn, .pad, .periph, .portChangeIrq,
		.wakeRequest);
	pin_board u_board (.pad, .drv, .ext, .padIn);
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		checks_done++;
		if (got !== want) begin
			errors++;
			$display("FAIL %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic bus(input logic r, input logic [7:0] a, v, m = 8'hff);
		if (r)
			expQ.push_back(v);
		req <= '{addr: a, wdata: v, wrMask: m, wr: !r, rd: r};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask : bus
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		errors++;
		print_verdict();
	end
	always @(posedge clk) begin
		rdPend <= req.rd && !rst;
		if (rdPend)
			chk(rdata, expQ.pop_front());
	end
	initial begin
		rst = 1'b1;
		req = '0;
		periph = '0;
		drv = 6'h3f;
		ext = 6'h00;
		void'($urandom(32'hbd382d50));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1, 8'h85, 8'h3f);
		bus(1, 8'h95, 8'h37);
		bus(1, 8'h96, 8'h00);
		bus(1, 8'h40, 8'h00);
		e = 6'($urandom);
		ext <= e;
		repeat (4) @(posedge clk);
		bus(0, 8'h05, 8'h00, 8'h00);
		bus(0, 8'h85, 8'h00);
		repeat (2) @(posedge clk);
		chk({2'b00, pad.oe}, 8'h37);
		chk({2'b00, pad.out & 6'h37}, {2'b00, e & 6'h37});
		bus(1, 8'h85, 8'h08);
		for (n = 0; n < 4; n++) begin
			d = 8'($urandom);
			bus(0, 8'h05, d);
			repeat (3) @(posedge clk);
			bus(1, 8'h05, {2'b00, d[5:0] & 6'h37 | e & 6'h08});
		end
		bus(0, 8'h85, 8'h3f);
		@(posedge clk);
		chk({2'b00, pad.oe}, 8'h00);
		drv <= 6'h00;
		ext <= 6'($urandom);
		bus(0, 8'h95, 8'h05);
		@(posedge clk);
		chk({2'b00, pad.pullupOn}, 8'h00);
		bus(0, 8'ha0, 8'h00);
		@(posedge clk);
		chk({2'b00, pad.pullupOn}, 8'h05);
		bus(0, 8'h85, 8'h3e);
		@(posedge clk);
		chk({2'b00, pad.pullupOn}, 8'h04);
		drv <= 6'h3f;
		ext <= 6'h3f;
		bus(0, 8'h85, 8'h3f);
		bus(0, 8'ha2, 8'h03);
		bus(0, 8'ha0, 8'h02);
		bus(1, 8'h05, 8'h34);
		bus(0, 8'ha2, 8'h00);
		bus(0, 8'h96, 8'h01);
		bus(1, 8'h05, 8'h37);
		ext <= 6'h3e;
		for (n = 0; n < 10 && wakeRequest !== 1'b1; n++)
			@(posedge clk);
		chk({6'h00, portChangeIrq, wakeRequest}, 8'h01);
		bus(0, 8'ha0, 8'h06);
		@(posedge clk);
		chk({7'h00, portChangeIrq}, 8'h01);
		bus(1, 8'ha1, 8'h03);
		bus(1, 8'h05, 8'h36);
		bus(1, 8'ha1, 8'h01);
		bus(0, 8'ha1, 8'h01);
		@(posedge clk);
		chk({6'h00, portChangeIrq, wakeRequest}, 8'h00);
		bus(1, 8'ha1, 8'h00);
		p = 18'($urandom) | 18'h3f000;
		periph <= p;
		repeat (3) @(posedge clk);
		chk({2'b00, pad.out}, {2'b00, p.out});
		chk({2'b00, pad.oe}, {2'b00, p.oe & 6'h37});
		periph <= '0;
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule : tb
bind six_pin_gpio_port six_pin_gpio_port_asserts u_chk (.clk, .rst, .req, .rdata, .pad,
	.periph, .portChangeIrq, .wakeRequest);
